// ### rtl/ipr_pkg.sv
package ipr_pkg;
  // ==========================================================
  // Register map
  localparam logic [31:0] PRIO_REG_OFFSET = 32'h0000_0000;
  localparam logic [15:0] PRIO_RESET = 16'h4444;
  localparam logic [15:0] PRIO_IMPL_MASK = 16'h7777;
  // ==========================================================
  // Field positions (low bit of each 3-bit field)
  localparam int RX_LSB = 12;
  localparam int SPI_EV_LSB = 8;
  localparam int SPI_FLT_LSB = 4;
  localparam int TMR3_LSB = 0;
  localparam int FIELD_W = 3;
  localparam int NUM_SRC = 4;
  localparam logic [2:0] PRIO_DISABLED = 3'h0;

  // Bundle of the four decoded priority levels
  typedef struct packed {
    logic [2:0] serial_rx_irq_priority;
    logic [2:0] spi_event_irq_priority;
    logic [2:0] spi_fault_irq_priority;
    logic [2:0] timer3_irq_priority;
  } ipr_prio_t;

  typedef struct packed {
    logic serial_rx;
    logic spi_event;
    logic spi_fault;
    logic timer3;
  } ipr_en_t;
endpackage : ipr_pkg

// ### rtl/ipr_prio_reg.sv
`timescale 1ns/1ps
module ipr_prio_reg (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output ipr_pkg::ipr_prio_t prio,
  output ipr_pkg::ipr_en_t src_en
);
  // ==========================================================
  // Bus address phase capture
  logic wr_pend_ff;
  logic [15:0] prio_ff;
  logic [31:0] hrdata_ff;
  logic hit;
  logic [15:0] nxt_prio;

  assign hit = hsel && hready && htrans[1] && (haddr[31:2] == ipr_pkg::PRIO_REG_OFFSET[31:2]);
  // Zero-wait slave: every transfer completes in one data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  // Write waits for data phase, as hwdata only appears then
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wr_pend_ff <= 1'b0;
    end else begin
      wr_pend_ff <= hit && hwrite;
    end
  end

  // ==========================================================
  // Priority register
  assign nxt_prio = hwdata[15:0] & ipr_pkg::PRIO_IMPL_MASK;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prio_ff <= ipr_pkg::PRIO_RESET;
    end else if (wr_pend_ff) begin
      prio_ff <= nxt_prio;
    end
  end

  // Read data registered; unmapped words read zero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (hit && !hwrite) begin
      hrdata_ff <= {16'h0000, prio_ff};
    end else begin
      hrdata_ff <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Field decode: value is the level itself, zero disables
  assign prio.serial_rx_irq_priority = prio_ff[ipr_pkg::RX_LSB +: ipr_pkg::FIELD_W];
  assign prio.spi_event_irq_priority = prio_ff[ipr_pkg::SPI_EV_LSB +: ipr_pkg::FIELD_W];
  assign prio.spi_fault_irq_priority = prio_ff[ipr_pkg::SPI_FLT_LSB +: ipr_pkg::FIELD_W];
  assign prio.timer3_irq_priority = prio_ff[ipr_pkg::TMR3_LSB +: ipr_pkg::FIELD_W];

  // Source enable per field, order matches prio struct
  genvar gi;
  generate
    for (gi = 0; gi < ipr_pkg::NUM_SRC; gi++) begin : g_en
      assign src_en[gi] = (prio_ff[gi*4 +: 3] != ipr_pkg::PRIO_DISABLED);
    end
  endgenerate

  // ==========================================================
  // Checks

  // Address phase of a write that hits the register
  sequence wr_addr_s;
    hit && hwrite;
  endsequence

  // Data phase of that write, hwdata on the bus
  sequence wr_data_s;
    wr_pend_ff;
  endsequence

  // Address phase of a read that hits the register
  sequence rd_addr_s;
    hit && !hwrite;
  endsequence

  // Unimplemented gaps can never hold a one, whatever was written
  gap_bits_zero_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (prio_ff & ~ipr_pkg::PRIO_IMPL_MASK) == 16'h0000
  ) else $error("gap bit set");

  // Every field comes out of reset at level 4
  reset_value_a: assert property (
    @(posedge core_clk)
    !rstn
    |=> prio_ff == ipr_pkg::PRIO_RESET
  ) else $error("bad reset value");

  // Level 4 is nonzero, so every source is enabled after reset
  reset_enable_a: assert property (
    @(posedge core_clk)
    !rstn
    |=> src_en == 4'hF
  ) else $error("bad reset enables");

  // A hit write always moves on to its data phase
  write_flow_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    wr_addr_s
    |=> wr_data_s
  ) else $error("write lost");

  // Receiver field takes hwdata bits 14 to 12
  rx_write_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    wr_data_s
    |=> prio.serial_rx_irq_priority == $past(hwdata[14:12])
  ) else $error("rx field");

  // Event field takes hwdata bits 10 to 8
  spi_write_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    wr_data_s
    |=> prio.spi_event_irq_priority == $past(hwdata[10:8])
  ) else $error("spi field");

  // Fault field takes its code straight as its level
  fault_write_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    wr_data_s
    |=> prio.spi_fault_irq_priority == $past(hwdata[6:4])
  ) else $error("fault field");

  // Timer field takes its code straight as its level
  timer_write_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    wr_data_s
    |=> prio.timer3_irq_priority == $past(hwdata[2:0])
  ) else $error("timer field");

  // All ones is the top level, not some remapped code
  top_level_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    wr_data_s ##0 (hwdata[14:12] == 3'h7)
    |=> prio.serial_rx_irq_priority == 3'h7
  ) else $error("level 7");

  // Code one is the lowest level that still fires
  lowest_level_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    wr_data_s ##0 (hwdata[10:8] == 3'h1)
    |=> prio.spi_event_irq_priority == 3'h1 && src_en.spi_event
  ) else $error("level 1");

  // Code zero turns the source off
  disabled_off_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    wr_data_s ##0 (hwdata[6:4] == 3'h0)
    |=> !src_en.spi_fault
  ) else $error("fault not disabled");

  // Enables follow the fields at all times, all four of them
  disable_src_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    src_en == {prio_ff[14:12] != 3'h0, prio_ff[10:8] != 3'h0,
               prio_ff[6:4] != 3'h0, prio_ff[2:0] != 3'h0}
  ) else $error("enable decode");

  // Read returns the register as it stood at the address phase
  read_back_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    rd_addr_s ##0 !wr_pend_ff
    |=> hrdata == {16'h0000, $past(prio_ff)}
  ) else $error("read");

  // Outside a read data phase the bus sees zero
  read_idle_zero_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !(hit && !hwrite)
    |=> hrdata == 32'h0000_0000
  ) else $error("read data leak");

  // Upper half of the word never carries anything
  upper_zero_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    hrdata[31:16] == 16'h0000
  ) else $error("upper half set");

  // Zero-wait OKAY slave: the bus never stalls or errors
  zero_wait_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    hreadyout && !hresp
  ) else $error("bus stall");

  // Only a write data phase may change the register
  hold_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !wr_pend_ff
    |=> $stable(prio_ff)
  ) else $error("spurious write");
endmodule : ipr_prio_reg

// ### testbench/ipr_prio_reg_tb.sv
`timescale 1ns/1ps
module interrupt_priority_reg_slice_test;
  logic core_clk = 0, rstn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [15:0] e;
  logic [15:0] pat [5] = '{16'hFFFF, 16'h0000, 16'h1111, 16'h7777, 16'hA5C3};
  ipr_pkg::ipr_prio_t prio;
  ipr_pkg::ipr_en_t src_en;
  int miscompares = 0, n_compared = 0, cycles = 0;
  // ==========
  // Clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end
  // Slave ready fed back as bus ready, since it is the only slave
  ipr_prio_reg uut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .prio(prio), .src_en(src_en));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // ==========
  // Single word transfer; read data kept in rd, taken while it stands
  task automatic xfer(logic wr, logic [31:0] a, logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge core_clk);
      rd = hrdata;
    end while (hreadyout !== 1'h1);
  endtask : xfer
  task automatic conclude();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // ==========
  // Reset value, field patterns, then an unmapped place
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'h1;
    xfer(1'h0, ipr_pkg::PRIO_REG_OFFSET, 32'h0);
    check("reset", rd, 32'h4444);
    check("okay", {30'h0, hreadyout, hresp}, 32'h2);
    check("reset_en", 32'(src_en), 32'hF);
    foreach (pat[i]) begin
      e = pat[i] & 16'h7777;
      xfer(1'h1, ipr_pkg::PRIO_REG_OFFSET, {16'hFFFF, pat[i]});
      #1 check("prio", 32'(prio), 32'({e[14:12], e[10:8], e[6:4], e[2:0]}));
      check("en", 32'(src_en), 32'({|e[14:12], |e[10:8], |e[6:4], |e[2:0]}));
      xfer(1'h0, ipr_pkg::PRIO_REG_OFFSET, 32'h0);
      check("readback", rd, {16'h0, e});
    end
    xfer(1'h1, 32'h10, 32'h1111);
    xfer(1'h0, 32'h10, 32'h0);
    check("unmapped", {rd[31:1], hresp}, 32'h0);
    xfer(1'h0, ipr_pkg::PRIO_REG_OFFSET, 32'h0);
    check("kept", rd, 32'h2543);
    conclude();
  end
endmodule : interrupt_priority_reg_slice_test
